// [common/exec_defines.svh]
`ifndef EXEC_DEFINES_SVH
`define EXEC_DEFINES_SVH
`define N_TRAP_NORM 8'h0e
`define N_TRAP_ADV 8'h10
`define N_RTE 8'h0a
`define N_SHORT 8'h02
`define N_MEM_CCR 8'h08
`define N_MOVE_HEAD 8'h04
`define N_MOVE_TAIL 8'h04
`define C_FIRST 8'h01
`define C_SECOND 8'h02
`define C_THIRD 8'h03
`define C_FOURTH 8'h04
`define C_VEC 8'h05
`define C_VEC_DATA 8'h06
`define STEP_READ 2'h0
`define STEP_PUSH 2'h1
`define STEP_WRITE 2'h2
`define STEP_COUNT 2'h3
`define PH_HEAD 2'h0
`define PH_BODY 2'h1
`define PH_TAIL 2'h2
`define VEC_BASE 32'h0000_0010
`define CCR_RESET 8'h80
`define WORD_STEP 32'h0000_0002
`define BYTE_STEP 32'h0000_0001
`define CNT_STEP 16'h0001
`define MOVE_FIFO_WIDTH 8
`define MOVE_FIFO_DEPTH 32
`endif

// [common/exec_pkg.sv]
package exec_pkg;
    typedef enum logic [3:0] {
        software_trap         = 4'h0,
        exception_return      = 4'h1,
        sleep_enter           = 4'h2,
        flags_load_imm        = 4'h3,
        flags_load_reg        = 4'h4,
        flags_load_postinc    = 4'h5,
        flags_store_predec    = 4'h6,
        flags_store_reg       = 4'h7,
        flags_and_imm         = 4'h8,
        flags_or_imm          = 4'h9,
        flags_xor_imm         = 4'ha,
        no_operation          = 4'hb,
        block_move_byte_count = 4'hc,
        block_move_word_count = 4'hd
    } op_e;
    typedef enum logic [3:0] {
        st_idle  = 4'h1,
        st_exec  = 4'h2,
        st_move  = 4'h4,
        st_sleep = 4'h8
    } state_e;
endpackage

// [design/system_control_block_move_exec.sv]
`timescale 1ns/10ps
`include "exec_defines.svh"

module move_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0]    rd;
    logic [AW-1:0]    wr;
    logic [AW:0]      fill;
    logic [AW-1:0]    next_rd;
    logic [AW-1:0]    next_wr;
    logic [AW:0]      next_fill;
    logic             push;
    logic             pop;

    assign in_ready  = fill != (AW+1)'(DEPTH);
    assign out_valid = fill != '0;
    assign out_data  = store[rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_rd   = pop ? rd + 1'b1 : rd;
        next_wr   = push ? wr + 1'b1 : wr;
        next_fill = fill + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd   <= '0;
            wr   <= '0;
            fill <= '0;
        end else begin
            rd   <= next_rd;
            wr   <= next_wr;
            fill <= next_fill;
        end
    end

    // Storage has no reset so it can map onto plain RAM
    always_ff @(posedge clock) begin
        if (push) begin
            store[wr] <= in_data;
        end
    end
endmodule // move_fifo

module system_control_block_move_exec
    import exec_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        start,
    input  wire op_e         op,
    input  wire logic [7:0]  imm,
    input  wire logic        advanced,
    input  wire logic [7:0]  gpr_in,
    input  wire logic [31:0] pc_in,
    input  wire logic [31:0] sp_in,
    input  wire logic [31:0] ptr_in,
    input  wire logic [31:0] src_in,
    input  wire logic [31:0] dst_in,
    input  wire logic [15:0] count_in,
    input  wire logic        wake,
    input  wire logic [15:0] mem_rdata,
    input  wire logic        mem_wr_ready,
    output logic             busy,
    output logic             done,
    output logic             sleeping,
    output logic [7:0]       condition_code_register,
    output logic [7:0]       gpr_out,
    output logic [31:0]      pc_out,
    output logic [31:0]      sp_out,
    output logic [31:0]      ptr_out,
    output logic [31:0]      src_out,
    output logic [31:0]      dst_out,
    output logic [15:0]      count_out,
    output logic             mem_req,
    output logic             mem_we,
    output logic             mem_word,
    output logic [31:0]      mem_addr,
    output logic [15:0]      mem_wdata
);
    logic rst_meta_n;
    logic rst_n;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    function automatic logic [7:0] op_states(input op_e o, input logic adv);
        case (o)
            software_trap:      op_states = adv ? `N_TRAP_ADV : `N_TRAP_NORM;
            exception_return:   op_states = `N_RTE;
            flags_load_postinc: op_states = `N_MEM_CCR;
            flags_store_predec: op_states = `N_MEM_CCR;
            default:            op_states = `N_SHORT;
        endcase
    endfunction

    // Byte variant looks only at the low byte and leaves the high byte alone
    function automatic logic [15:0] count_dec(input logic wide, input logic [15:0] c);
        count_dec = wide ? c - `CNT_STEP : {c[15:8], 8'(c[7:0] - `CNT_STEP)};
    endfunction

    function automatic logic count_zero(input logic wide, input logic [15:0] c);
        count_zero = wide ? (c == '0) : (c[7:0] == '0);
    endfunction

    state_e      st, next_st;
    op_e         op_q, next_op_q;
    logic        adv_q, next_adv_q;
    logic [7:0]  imm_q, next_imm_q;
    logic [7:0]  gpr_q, next_gpr_q;
    logic [7:0]  cnt, next_cnt;
    logic [1:0]  phase, next_phase;
    logic [1:0]  step, next_step;
    logic        rd_pend, next_rd_pend;
    logic        wrote, next_wrote;
    logic [15:0] reads_left, next_reads_left;
    logic        next_busy, next_done, next_sleeping;
    logic [7:0]  next_ccr, next_gpr_out;
    logic [31:0] next_pc, next_sp, next_ptr, next_src, next_dst;
    logic [15:0] next_count;
    logic        next_mem_req, next_mem_we, next_mem_word;
    logic [31:0] next_mem_addr;
    logic [15:0] next_mem_wdata;
    logic        wide;
    logic        f_push, f_in_ready, f_out_valid, f_pop;
    logic [7:0]  f_out_data;

    assign wide = op_q == block_move_word_count;

    // Writes may be held off, so reads run ahead and the FIFO fills up
    move_fifo #(.WIDTH(`MOVE_FIFO_WIDTH), .DEPTH(`MOVE_FIFO_DEPTH)) move_fifo_inst (
        .clock     (clock),
        .rst_n     (rst_n),
        .in_valid  (f_push),
        .in_ready  (f_in_ready),
        .in_data   (mem_rdata[7:0]),
        .out_valid (f_out_valid),
        .out_ready (f_pop),
        .out_data  (f_out_data)
    );

    always_comb begin
        next_st = st; next_op_q = op_q; next_adv_q = adv_q; next_imm_q = imm_q;
        next_gpr_q = gpr_q; next_cnt = cnt + 8'h01; next_phase = phase;
        next_step = step + 2'h1; next_rd_pend = 1'b0; next_wrote = wrote;
        next_reads_left = reads_left; next_busy = busy; next_done = 1'b0;
        next_sleeping = sleeping; next_ccr = condition_code_register; next_gpr_out = gpr_out;
        next_pc = pc_out; next_sp = sp_out; next_ptr = ptr_out; next_src = src_out;
        next_dst = dst_out; next_count = count_out; next_mem_req = 1'b0;
        next_mem_we = 1'b0; next_mem_word = 1'b1; next_mem_addr = mem_addr;
        next_mem_wdata = mem_wdata; f_push = 1'b0; f_pop = 1'b0;
        case (st)
            st_idle: begin
                if (start) begin
                    next_op_q = op; next_adv_q = advanced; next_imm_q = imm;
                    next_gpr_q = gpr_in; next_pc = pc_in; next_sp = sp_in;
                    next_ptr = ptr_in; next_src = src_in; next_dst = dst_in;
                    next_count = count_in; next_reads_left = count_in;
                    next_cnt = `C_FIRST; next_phase = `PH_HEAD; next_busy = 1'b1;
                    next_st = (op == block_move_byte_count || op == block_move_word_count)
                              ? st_move : st_exec;
                end
            end
            st_exec: begin
                case (op_q)
                    software_trap: begin
                        // Flags are pushed but never written here
                        if (cnt == `C_FIRST || (cnt == `C_SECOND && adv_q) || cnt == `C_THIRD) begin
                            next_sp = sp_out - `WORD_STEP;
                            next_mem_req = 1'b1; next_mem_we = 1'b1;
                            next_mem_addr = sp_out - `WORD_STEP;
                            next_mem_wdata = cnt == `C_FIRST ? pc_out[15:0]
                                           : cnt == `C_SECOND ? pc_out[31:16] : {condition_code_register, condition_code_register};
                        end
                        if (cnt == `C_VEC) begin
                            next_mem_req = 1'b1;
                            next_mem_addr = `VEC_BASE + {29'h0000_0000, imm_q[1:0], 1'b0};
                        end
                        if (cnt == `C_VEC_DATA) next_pc = {16'h0000, mem_rdata};
                    end
                    exception_return: begin
                        if (cnt == `C_FIRST || cnt == `C_THIRD) begin
                            next_mem_req = 1'b1; next_mem_addr = sp_out;
                            next_sp = sp_out + `WORD_STEP;
                        end
                        if (cnt == `C_SECOND) next_ccr = mem_rdata[15:8];
                        if (cnt == `C_FOURTH) next_pc = {16'h0000, mem_rdata};
                    end
                    flags_load_postinc: begin
                        if (cnt == `C_FIRST) begin
                            next_mem_req = 1'b1; next_mem_addr = ptr_out;
                            next_ptr = ptr_out + `WORD_STEP;
                        end
                        if (cnt == `C_SECOND) next_ccr = mem_rdata[15:8];
                    end
                    flags_store_predec: begin
                        if (cnt == `C_FIRST) begin
                            next_ptr = ptr_out - `WORD_STEP;
                            next_mem_req = 1'b1; next_mem_we = 1'b1;
                            next_mem_addr = ptr_out - `WORD_STEP; next_mem_wdata = {condition_code_register, condition_code_register};
                        end
                    end
                    flags_load_imm: if (cnt == `C_FIRST) next_ccr = imm_q;
                    flags_load_reg: if (cnt == `C_FIRST) next_ccr = gpr_q;
                    flags_store_reg: if (cnt == `C_FIRST) next_gpr_out = condition_code_register;
                    flags_and_imm: if (cnt == `C_FIRST) next_ccr = condition_code_register & imm_q;
                    flags_or_imm: if (cnt == `C_FIRST) next_ccr = condition_code_register | imm_q;
                    flags_xor_imm: if (cnt == `C_FIRST) next_ccr = condition_code_register ^ imm_q;
                    no_operation: if (cnt == `C_FIRST) next_pc = pc_out + `WORD_STEP;
                    default: ;
                endcase
                if (cnt == op_states(op_q, adv_q)) begin
                    next_busy = 1'b0; next_done = 1'b1;
                    next_st = op_q == sleep_enter ? st_sleep : st_idle;
                    next_sleeping = op_q == sleep_enter;
                end
            end
            st_move: begin
                case (phase)
                    `PH_HEAD: if (cnt == `N_MOVE_HEAD) begin
                        next_cnt = `C_FIRST; next_step = `STEP_READ; next_wrote = 1'b0;
                        next_phase = count_zero(wide, count_out) ? `PH_TAIL : `PH_BODY;
                    end
                    `PH_BODY: begin
                        case (step)
                            `STEP_READ: if (!count_zero(wide, reads_left) && f_in_ready) begin
                                next_mem_req = 1'b1; next_mem_word = 1'b0;
                                next_mem_addr = src_out; next_rd_pend = 1'b1;
                            end
                            `STEP_PUSH: if (rd_pend) begin
                                f_push = 1'b1;
                                next_src = src_out + `BYTE_STEP;
                                next_reads_left = count_dec(wide, reads_left);
                            end
                            `STEP_WRITE: if (f_out_valid && mem_wr_ready) begin
                                f_pop = 1'b1; next_mem_req = 1'b1; next_mem_we = 1'b1;
                                next_mem_word = 1'b0; next_mem_addr = dst_out;
                                next_mem_wdata = {8'h00, f_out_data};
                                next_dst = dst_out + `BYTE_STEP;
                                next_wrote = 1'b1;
                            end
                            default: begin
                                next_wrote = 1'b0;
                                if (wrote) begin
                                    next_count = count_dec(wide, count_out);
                                    if (count_zero(wide, count_dec(wide, count_out))) begin
                                        next_phase = `PH_TAIL; next_cnt = `C_FIRST;
                                    end
                                end
                            end
                        endcase
                    end
                    default: if (cnt == `N_MOVE_TAIL) begin
                        next_busy = 1'b0; next_done = 1'b1; next_st = st_idle;
                    end
                endcase
            end
            st_sleep: if (wake) begin
                next_sleeping = 1'b0; next_st = st_idle;
            end
            default: next_st = st_idle;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st <= st_idle; op_q <= no_operation; adv_q <= 1'b0; imm_q <= '0; gpr_q <= '0;
            cnt <= '0; phase <= `PH_HEAD; step <= `STEP_READ; rd_pend <= 1'b0;
            wrote <= 1'b0; reads_left <= '0; busy <= 1'b0; done <= 1'b0;
            sleeping <= 1'b0; condition_code_register <= `CCR_RESET; gpr_out <= '0; pc_out <= '0;
            sp_out <= '0; ptr_out <= '0; src_out <= '0; dst_out <= '0; count_out <= '0;
            mem_req <= 1'b0; mem_we <= 1'b0; mem_word <= 1'b1; mem_addr <= '0;
            mem_wdata <= '0;
        end else begin
            st <= next_st; op_q <= next_op_q; adv_q <= next_adv_q; imm_q <= next_imm_q;
            gpr_q <= next_gpr_q; cnt <= next_cnt; phase <= next_phase; step <= next_step;
            rd_pend <= next_rd_pend; wrote <= next_wrote; reads_left <= next_reads_left;
            busy <= next_busy; done <= next_done; sleeping <= next_sleeping;
            condition_code_register <= next_ccr; gpr_out <= next_gpr_out; pc_out <= next_pc; sp_out <= next_sp;
            ptr_out <= next_ptr; src_out <= next_src; dst_out <= next_dst;
            count_out <= next_count; mem_req <= next_mem_req; mem_we <= next_mem_we;
            mem_word <= next_mem_word; mem_addr <= next_mem_addr;
            mem_wdata <= next_mem_wdata;
        end
    end

    a_trap_normal_len: assert property (@(posedge clock) disable iff (!rst_n)
        st == st_idle && start && op == software_trap && !advanced |-> ##15 done)
        else $error("trap normal length wrong");
    a_trap_adv_len: assert property (@(posedge clock) disable iff (!rst_n)
        st == st_idle && start && op == software_trap && advanced |-> ##17 done)
        else $error("trap advanced length wrong");
    a_reg_load_ccr: assert property (@(posedge clock) disable iff (!rst_n)
        st == st_idle && start && op == flags_load_reg |-> ##3 (done && condition_code_register == $past(gpr_in, 3)))
        else $error("register flags load wrong");
    a_postinc_ptr: assert property (@(posedge clock) disable iff (!rst_n)
        st == st_idle && start && op == flags_load_postinc
        |-> ##9 (done && ptr_out == $past(ptr_in, 9) + `WORD_STEP))
        else $error("post-increment load wrong");
    a_predec_write: assert property (@(posedge clock) disable iff (!rst_n)
        st == st_idle && start && op == flags_store_predec
        |-> ##2 (mem_req && mem_we && mem_addr == $past(ptr_in, 2) - `WORD_STEP))
        else $error("pre-decrement store address wrong");
    a_xor_result: assert property (@(posedge clock) disable iff (!rst_n)
        st == st_idle && start && op == flags_xor_imm
        |-> ##3 (done && condition_code_register == ($past(condition_code_register, 3) ^ $past(imm, 3))))
        else $error("xor immediate result wrong");
    a_nop_pc: assert property (@(posedge clock) disable iff (!rst_n)
        st == st_idle && start && op == no_operation
        |-> ##3 (done && pc_out == $past(pc_in, 3) + `WORD_STEP))
        else $error("nop pc step wrong");
    a_sleep_entry: assert property (@(posedge clock) disable iff (!rst_n)
        st == st_idle && start && op == sleep_enter && !wake |-> ##3 (done && sleeping))
        else $error("sleep entry wrong");
    a_move_zero: assert property (@(posedge clock) disable iff (!rst_n)
        st == st_idle && start && op == block_move_byte_count && count_in[7:0] == 8'h00
        |-> ##9 (done && !mem_req))
        else $error("zero move length wrong");
    a_move_dst_step: assert property (@(posedge clock) disable iff (!rst_n)
        mem_req && mem_we && st == st_move |-> dst_out == mem_addr + `BYTE_STEP)
        else $error("destination step wrong");
    a_flags_kept: assert property (@(posedge clock) disable iff (!rst_n)
        st != st_idle && (op_q == flags_store_reg || op_q == flags_store_predec
        || op_q == software_trap || wide || op_q == block_move_byte_count) |=> $stable(condition_code_register))
        else $error("flags changed");
endmodule // system_control_block_move_exec

// [test/onchip_mem_model.sv]
`timescale 1ns/10ps
module onchip_mem_model (
    input  wire logic        clock,
    input  wire logic        stall,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic        mem_word,
    input  wire logic [31:0] mem_addr,
    input  wire logic [15:0] mem_wdata,
    output logic      [15:0] mem_rdata,
    output logic             mem_wr_ready
);
    logic [7:0] mem [0:255];
    logic [7:0] a;
    assign a = mem_addr[7:0];
    assign mem_wr_ready = !stall;
    // Answers within the request's own cycle, as on-chip memory does
    // Outside a read the bus shows the inverse so stale data cannot pass
    assign mem_rdata = (mem_req && !mem_we)
        ? (mem_word ? {mem[a], mem[a + 8'h01]} : {8'h00, mem[a]})
        : ~{mem[a], mem[a + 8'h01]};
    always @(posedge clock) begin
        if (mem_req && mem_we && mem_word) begin
            mem[a] <= mem_wdata[15:8];
            mem[a + 8'h01] <= mem_wdata[7:0];
        end else if (mem_req && mem_we) begin
            mem[a] <= mem_wdata[7:0];
        end
    end
endmodule // onchip_mem_model

// [test/test_system_control_block_move_exec.sv]
`timescale 1ns/10ps
module test_system_control_block_move_exec;
    import exec_pkg::*;
    logic        clock = 1'b0, nrst = 1'b0, start = 1'b0, advanced = 1'b0;
    logic        wake = 1'b0, stall = 1'b0;
    op_e         op = no_operation;
    logic [7:0]  imm = 8'h00, gpr_in = 8'h00;
    logic [31:0] pc_in = 32'h0000_0000, sp_in = 32'h0000_0000, ptr_in = 32'h0000_0000;
    logic [31:0] src_in = 32'h0000_0000, dst_in = 32'h0000_0000;
    logic [15:0] count_in = 16'h0000;
    logic        busy, done, sleeping, mem_req, mem_we, mem_word, mem_wr_ready;
    logic [7:0]  condition_code_register, gpr_out;
    logic [31:0] pc_out, sp_out, ptr_out, src_out, dst_out, mem_addr;
    logic [15:0] count_out, mem_wdata, mem_rdata;
    int          mismatches = 0;
    int          n_tests = 0;
    always #10 clock = ~clock;
    system_control_block_move_exec system_control_block_move_exec_inst (.clock, .nrst, .start,
        .op, .imm, .advanced, .gpr_in, .pc_in, .sp_in, .ptr_in, .src_in, .dst_in, .count_in,
        .wake, .mem_rdata, .mem_wr_ready, .busy, .done, .sleeping, .condition_code_register, .gpr_out, .pc_out,
        .sp_out, .ptr_out, .src_out, .dst_out, .count_out, .mem_req, .mem_we, .mem_word,
        .mem_addr, .mem_wdata);
    onchip_mem_model onchip_mem_model_inst (.clock, .stall, .mem_req, .mem_we, .mem_word,
        .mem_addr, .mem_wdata, .mem_rdata, .mem_wr_ready);
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Issue one instruction and measure states; n below 0 skips the timing check
    task automatic run(input op_e o, input logic [7:0] im, input int n);
        int i;
        @(posedge clock); #1;
        op = o; imm = im; start = 1'b1;
        @(posedge clock); #1;
        start = 1'b0;
        for (i = 0; i < 400 && done !== 1'b1; i++) begin
            @(posedge clock); #1;
        end
        if (i == 400) begin
            mismatches++;
            $display("ERROR done expected 1 seen timeout");
            tally_and_finish();
        end else if (n >= 0) begin
            chk("states", 32'(n), 32'(i));
        end
    endtask
    task automatic imm_ops;
        op_e        ops [4] = '{flags_load_imm, flags_xor_imm, flags_and_imm, flags_or_imm};
        logic [7:0] ims [4] = '{8'h5a, 8'hff, 8'h0f, 8'h30};
        logic [7:0] exp [4] = '{8'ha5, 8'ha5, 8'h05, 8'h35};
        for (int k = 0; k < 4; k++) begin
            run(ops[k], ims[k], 2);
            chk("ccr imm", {24'h0, (k == 0) ? ims[0] : exp[k]}, {24'h0, condition_code_register});
        end
    endtask
    task automatic reg_ops;
        gpr_in = 8'hc3; pc_in = 32'h0000_0100;
        run(flags_load_reg, 8'h00, 2);
        chk("ccr reg load", 32'h0000_00c3, {24'h0, condition_code_register});
        run(flags_store_reg, 8'h00, 2);
        chk("gpr_out", 32'h0000_00c3, {24'h0, gpr_out});
        run(no_operation, 8'h00, 2);
        chk("pc nop", 32'h0000_0102, pc_out);
        chk("ccr kept", 32'h0000_00c3, {24'h0, condition_code_register});
    endtask
    task automatic mem_flags;
        onchip_mem_model_inst.mem[8'h40] = 8'h9e;
        ptr_in = 32'h0000_0040;
        run(flags_load_postinc, 8'h00, 8);
        chk("ccr postinc", 32'h0000_009e, {24'h0, condition_code_register});
        chk("ptr postinc", 32'h0000_0042, ptr_out);
        ptr_in = 32'h0000_0050;
        run(flags_store_predec, 8'h00, 8);
        chk("ptr predec", 32'h0000_004e, ptr_out);
        chk("stored flags", 32'h0000_009e, {24'h0, onchip_mem_model_inst.mem[8'h4e]});
    endtask
    task automatic trap_ret;
        pc_in = 32'h0000_1234; sp_in = 32'h0000_0090;
        for (int k = 0; k < 5; k++) begin
            onchip_mem_model_inst.mem[8'h10 + 8'(2 * k)] = 8'h01;
            onchip_mem_model_inst.mem[8'h11 + 8'(2 * k)] = 8'(k);
            advanced = (k == 4);
            run(software_trap, 8'(k % 4), (k == 4) ? 16 : 14);
            chk("trap pc", 32'h0000_0100 + 32'(k % 4), pc_out);
            chk("trap sp", (k == 4) ? 32'h0000_008a : 32'h0000_008c, sp_out);
            chk("pushed pc", 32'h0000_1234, {16'h0, onchip_mem_model_inst.mem[8'h8e],
                onchip_mem_model_inst.mem[8'h8f]});
            chk("pushed flags", 32'h0000_009e, {24'h0, onchip_mem_model_inst.mem[
                (k == 4) ? 8'h8a : 8'h8c]});
            chk("trap ccr", 32'h0000_009e, {24'h0, condition_code_register});
        end
        advanced = 1'b0; sp_in = 32'h0000_008c;
        onchip_mem_model_inst.mem[8'h8c] = 8'h3c;
        run(exception_return, 8'h00, 10);
        chk("ret ccr", 32'h0000_003c, {24'h0, condition_code_register});
        chk("ret pc", 32'h0000_1234, pc_out);
        chk("ret sp", 32'h0000_0090, sp_out);
    endtask
    task automatic moves;
        for (int i = 0; i < 40; i++) onchip_mem_model_inst.mem[8'ha0 + 8'(i)] = 8'(i) ^ 8'h5a;
        src_in = 32'h0000_00a0; dst_in = 32'h0000_00d0; count_in = 16'h0103;
        run(block_move_byte_count, 8'h00, 20);
        chk("byte count", 32'h0000_0100, {16'h0, count_out});
        chk("src end", 32'h0000_00a3, src_out);
        chk("dst end", 32'h0000_00d3, dst_out);
        chk("ccr move", 32'h0000_003c, {24'h0, condition_code_register});
        count_in = 16'h0100;
        run(block_move_byte_count, 8'h00, 8);
        chk("zero src", 32'h0000_00a0, src_out);
        // Stall writes long enough that the buffer fills and reads are held off
        count_in = 16'h0028; stall = 1'b1;
        fork
            begin
                repeat (150) @(posedge clock);
                #1 stall = 1'b0;
            end
        join_none
        run(block_move_word_count, 8'h00, -1);
        chk("word count", 32'h0000_0000, {16'h0, count_out});
        chk("dst word end", 32'h0000_00f8, dst_out);
        for (int i = 0; i < 40; i++)
            chk("moved byte", 32'(8'(i) ^ 8'h5a),
                {24'h0, onchip_mem_model_inst.mem[8'hd0 + 8'(i)]});
    endtask
    task automatic sleep_wake;
        int i;
        run(sleep_enter, 8'h00, 2);
        chk("sleeping", 32'h0000_0001, {31'h0, sleeping});
        op = no_operation; start = 1'b1;
        repeat (3) @(posedge clock);
        #1 chk("busy refused", 32'h0000_0000, {31'h0, busy});
        start = 1'b0; wake = 1'b1;
        for (i = 0; i < 10 && sleeping !== 1'b0; i++) begin
            @(posedge clock); #1;
        end
        wake = 1'b0;
        chk("woken", 32'h0000_0000, {31'h0, sleeping});
        chk("ccr sleep", 32'h0000_003c, {24'h0, condition_code_register});
    endtask
    initial begin
        repeat (3) @(posedge clock);
        #1 nrst = 1'b1;
        repeat (3) @(posedge clock);
        #1 chk("ccr reset", 32'h0000_0080, {24'h0, condition_code_register});
        imm_ops();
        reg_ops();
        mem_flags();
        trap_ret();
        moves();
        sleep_wake();
        tally_and_finish();
    end
endmodule // test_system_control_block_move_exec
